// ---- verilog/tos_timer.sv ----
`timescale 1ns/100ps
// How it works
// - Count source is clk, /2, /8 or companion underflow.
// - Downcount primary value, prescaler divides each count.
// - Underflow reloads counter, ends count, clears active.
// - Any stop reloads counter before halting.
// - Pulse lasts (n+1)(m+1) source periods.
// - Pulse needs start bit then a trigger.
// - Stop on underflow, oneshot stop, start clear, force.
// - Interrupt rises with pulse end after underflow.
// - Pin triggers only when pin trigger enable set.
// - Count registers read back live count values.
// - Writes while stopped load reload and counter.
// - Writes while counting load reload only.
// - Polarity bit sets idle output level; active is its inverse.
// - Trigger accepted only while count status is one.
// - Triggers are oneshot start write or pin edge.
// - Active flag sets within one source cycle later.
// - Trigger during active pulse is ignored.
// - Ignored pin trigger still sets pin request flag.
// - Trigger edge select affects only the oneshot trigger.
// - Secondary register takes no part in counting.
// - Forced stop halts at once; start clear stops.
module tos_timer (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic comp_underflow,
  input wire logic ext_trigger_pin,
  output logic timer_pulse_out,
  output logic timer_irq
);

  // Register map, low byte of each word only
  //   0x00 control: start, status copy, forced stop
  //   0x04 one-shot: start and stop strobes, active flag
  //   0x08 I/O control: polarity, trigger edge, pin enable
  //   0x0C count source select, two bits
  //   0x10 prescaler, reload on write, live count on read
  //   0x14 secondary, stored only in this mode
  //   0x18 primary, reload on write, live count on read
  //   0x1C pin interrupt control and request flag
  // Unmapped offsets read zero and ignore writes.
  // Upper byte lanes are never looked at.
  //
  // Bus timing
  //   Request taken on the edge that sees cyc, stb and no ack.
  //   Write lands on that same edge.
  //   Ack and read data follow one clock later, for one clock.
  //   A held request is not taken twice: ack masks it.
  //
  // Pulse timing
  //   Trigger moves the idle machine to the arm state.
  //   The next source tick starts the pulse and sets active.
  //   So active rises within one source period after a trigger.
  //   Prescaler counts down each tick, primary on its wrap.
  //   Primary wrap at zero is the underflow.
  //   Underflow reloads both counters and clears active.
  //   Pulse end and interrupt follow one clock later.
  //   Half a source period is rounded to one clock here.
  //   Limitation: slow sources end the pulse a little early.
  //
  // Stopping
  //   One-shot stop, forced stop or start cleared all stop.
  //   Each reloads both counters before going idle.
  //   Output drops to its idle level on the same edge.
  //   A stop while idle changes nothing in the counters.
  //
  // Trigger path
  //   Pin passes two flops before anything reads it.
  //   Edge detect runs on the second stage only.
  //   Sync flops reset to the pulled-up idle level.
  //   Hazard avoided: no false edge just after reset.
  //   Pin trigger edge and pin interrupt edge are separate.
  //   Pin interrupt flag keeps working during a pulse.
  //
  // Register writes while counting
  //   Only the reload copies change.
  //   The live counters pick them up at the next reload.
  //   So a new primary shows from the following pulse; a new prescaler from its next wrap.
  //
  // Software must not load zero into both count registers.
  // Nothing here guards against it; the pulse would be short.
  //
  // Every output comes straight from one flop of the state.
  // Trade-off: reads cost one clock of latency for clean timing.

  typedef enum logic [1:0] {TOS_IDLE, TOS_ARM, TOS_RUN} tos_state_t;

  typedef struct packed {
    tos_state_t st;
    logic [1:0] sync;
    logic pin_prev;
    logic [2:0] div;
    logic count_start_bit;
    logic count_status_flag;
    logic oneshot_active_flag;
    logic output_polarity_bit;
    logic pin_trigger_edge_sel;
    logic pin_trigger_enable;
    logic [1:0] src_sel;
    logic edge_mode_select;
    logic interrupt_edge_sense;
    logic interrupt_request_flag;
    logic irq_flag;
    logic [7:0] pre_reload;
    logic [7:0] pri_reload;
    logic [7:0] secondary_count_reg;
    logic [7:0] pre_cnt;
    logic [7:0] pri_cnt;
    logic pend;
    logic irq_pend;
    logic out;
    logic [31:0] rdata;
    logic ack;
  } tos_regs_t;

  tos_regs_t r_q;
  tos_regs_t r_d;

  logic tick;
  logic pin;
  logic rise;
  logic fall;
  logic pin_trig;
  logic pin_int;
  logic wr;
  logic rd;
  logic stopping;
  logic [7:0] wb0;

  // Two-flop synchroniser output and edge detection on the second stage
  assign pin = r_q.sync[1];
  assign rise = pin & ~r_q.pin_prev;
  assign fall = ~pin & r_q.pin_prev;
  // Timer edge select steers only the trigger path
  assign pin_trig = r_q.pin_trigger_enable & (r_q.pin_trigger_edge_sel ? rise : fall);
  // Interrupt edge uses its own sense bit, independent of the timer
  assign pin_int = r_q.edge_mode_select ? (rise | fall)
                 : (r_q.interrupt_edge_sense ? rise : fall);
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~r_q.ack & wb_sel_i[0];
  assign rd = wb_cyc_i & wb_stb_i & ~r_q.ack;
  assign wb0 = wb_dat_i[7:0];

  // Count source tick, one mclk wide
  // Free-running divider, so the first tick after a trigger may come late
  always_comb begin
    case (r_q.src_sel)
      tos_pkg::SRC_DIV1: begin
        // Every clock counts
        tick = 1'b1;
      end
      tos_pkg::SRC_DIV2: begin
        // Every second clock
        tick = r_q.div[0];
      end
      tos_pkg::SRC_DIV8: begin
        // Every eighth clock
        tick = &r_q.div;
      end
      tos_pkg::SRC_COMP: begin
        // Companion underflow is already a one-clock pulse
        tick = comp_underflow;
      end
      default: tick = 1'b1;
    endcase
  end

  // Stop requests coming from software this cycle
  always_comb begin
    stopping = 1'b0;
    if (wr && wb_adr_i[4:0] == tos_pkg::ADR_ONESHOT && wb0[tos_pkg::OS_STOP]) begin
      stopping = 1'b1;
    end
    if (wr && wb_adr_i[4:0] == tos_pkg::ADR_CTRL) begin
      if (wb0[tos_pkg::CTRL_FSTOP] || !wb0[tos_pkg::CTRL_START]) begin
        stopping = 1'b1;
      end
    end
  end

  // All next-state logic
  always_comb begin
    r_d = r_q;
    r_d.sync = {r_q.sync[0], ext_trigger_pin};
    r_d.pin_prev = pin;
    r_d.div = r_q.div + 3'd1;
    r_d.ack = rd;
    r_d.irq_flag = 1'b0;
    // Pin request flag: edge sets it even while a pulse runs
    if (pin_int) begin
      r_d.interrupt_request_flag = 1'b1;
    end
    // Counting state machine
    case (r_q.st)
      TOS_IDLE: begin
        if (r_q.count_status_flag && (pin_trig || (wr && wb_adr_i[4:0] == tos_pkg::ADR_ONESHOT
            && wb0[tos_pkg::OS_START]))) begin
          r_d.st = TOS_ARM;
        end
      end
      TOS_ARM: begin
        // Synchronise to the next source tick before going active
        if (tick) begin
          r_d.st = TOS_RUN;
          r_d.oneshot_active_flag = 1'b1;
          r_d.out = ~r_q.output_polarity_bit;
        end
      end
      TOS_RUN: begin
        // New triggers are simply not looked at here
        if (tick) begin
          if (r_q.pre_cnt != 8'h00) begin
            r_d.pre_cnt = r_q.pre_cnt - 8'd1;
          end else begin
            r_d.pre_cnt = r_q.pre_reload;
            if (r_q.pri_cnt != 8'h00) begin
              r_d.pri_cnt = r_q.pri_cnt - 8'd1;
            end else begin
              // Underflow: reload, end pulse after half a source cycle
              r_d.pri_cnt = r_q.pri_reload;
              r_d.st = TOS_IDLE;
              r_d.oneshot_active_flag = 1'b0;
              r_d.irq_pend = 1'b1;
            end
          end
        end
      end
      default: r_d.st = TOS_IDLE;
    endcase
    // Half source cycle approximated as one mclk after underflow
    if (r_q.irq_pend) begin
      r_d.irq_pend = 1'b0;
      r_d.irq_flag = 1'b1;
      r_d.out = r_q.output_polarity_bit;
    end
    // Software stop: reload and halt
    if (stopping && r_q.st != TOS_IDLE) begin
      r_d.st = TOS_IDLE;
      r_d.pre_cnt = r_q.pre_reload;
      r_d.pri_cnt = r_q.pri_reload;
      r_d.oneshot_active_flag = 1'b0;
      r_d.out = r_q.output_polarity_bit;
    end
    // Hold the active level through the clock between underflow and end
    if (r_d.st == TOS_IDLE && !r_q.irq_pend && !r_d.irq_pend) begin
      r_d.out = r_q.output_polarity_bit;
    end
    // Register writes
    if (wr) begin
      case (wb_adr_i[4:0])
        tos_pkg::ADR_CTRL: begin
          r_d.count_start_bit = wb0[tos_pkg::CTRL_START] & ~wb0[tos_pkg::CTRL_FSTOP];
          r_d.count_status_flag = r_d.count_start_bit;
        end
        tos_pkg::ADR_IOCTRL: begin
          r_d.output_polarity_bit = wb0[tos_pkg::IO_POL];
          r_d.pin_trigger_edge_sel = wb0[tos_pkg::IO_EDGE];
          r_d.pin_trigger_enable = wb0[tos_pkg::IO_PIN_EN];
        end
        tos_pkg::ADR_MODE: r_d.src_sel = wb0[1:0];
        tos_pkg::ADR_PRESCALE: begin
          r_d.pre_reload = wb0;
          if (r_q.st == TOS_IDLE) begin
            r_d.pre_cnt = wb0;
          end
        end
        tos_pkg::ADR_PRIMARY: begin
          r_d.pri_reload = wb0;
          if (r_q.st == TOS_IDLE) begin
            r_d.pri_cnt = wb0;
          end
        end
        // Stored only; never used for counting
        tos_pkg::ADR_SECONDARY: r_d.secondary_count_reg = wb0;
        tos_pkg::ADR_PININT: begin
          r_d.edge_mode_select = wb0[tos_pkg::PI_BOTH];
          r_d.interrupt_edge_sense = wb0[tos_pkg::PI_SENSE];
          // Clear by writing 0, a new edge this cycle wins
          if (!wb0[tos_pkg::PI_REQ] && !pin_int) begin
            r_d.interrupt_request_flag = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // Read mux, unmapped offsets read zero
    r_d.rdata = 32'h0000_0000;
    case (wb_adr_i[4:0])
      tos_pkg::ADR_CTRL: begin
        // Forced stop is a strobe and reads zero
        r_d.rdata[2:0] = {1'b0, r_q.count_status_flag, r_q.count_start_bit};
      end
      tos_pkg::ADR_ONESHOT: begin
        // Start and stop are strobes, only active reads back
        r_d.rdata[tos_pkg::OS_ACTIVE] = r_q.oneshot_active_flag;
      end
      tos_pkg::ADR_IOCTRL: begin
        r_d.rdata[3:0] = {r_q.pin_trigger_enable, r_q.pin_trigger_edge_sel,
                          1'b0, r_q.output_polarity_bit};
      end
      tos_pkg::ADR_MODE: begin
        r_d.rdata[1:0] = r_q.src_sel;
      end
      tos_pkg::ADR_PRESCALE: begin
        // Live counter, not the reload copy
        r_d.rdata[7:0] = r_q.pre_cnt;
      end
      tos_pkg::ADR_SECONDARY: begin
        r_d.rdata[7:0] = r_q.secondary_count_reg;
      end
      tos_pkg::ADR_PRIMARY: begin
        // Live counter, not the reload copy
        r_d.rdata[7:0] = r_q.pri_cnt;
      end
      tos_pkg::ADR_PININT: begin
        r_d.rdata[3:0] = {r_q.interrupt_request_flag, 1'b0,
                          r_q.interrupt_edge_sense, r_q.edge_mode_select};
      end
      default: r_d.rdata = 32'h0000_0000;
    endcase

    if (sys_rst) begin
      r_d = '0;
      r_d.st = TOS_IDLE;
      // Pin idles high, so no edge is seen as the flops fill
      r_d.sync = 2'b11;
      r_d.pin_prev = 1'b1;
      r_d.pre_reload = tos_pkg::RST_COUNT;
      r_d.pri_reload = tos_pkg::RST_COUNT;
      r_d.pre_cnt = tos_pkg::RST_COUNT;
      r_d.pri_cnt = tos_pkg::RST_COUNT;
      r_d.secondary_count_reg = tos_pkg::RST_COUNT;
    end
  end

  // Single state register, synchronous reset folded into r_d
  always_ff @(posedge mclk) begin
    r_q <= r_d;
  end

  assign wb_dat_o = r_q.rdata;
  assign wb_ack_o = r_q.ack;
  assign timer_pulse_out = r_q.out;
  assign timer_irq = r_q.irq_flag;

endmodule : tos_timer

// ---- verilog/tos_pkg.sv ----
package tos_pkg;
  // Register byte offsets on the Wishbone slave
  localparam logic [4:0] ADR_CTRL = 5'h00;
  localparam logic [4:0] ADR_ONESHOT = 5'h04;
  localparam logic [4:0] ADR_IOCTRL = 5'h08;
  localparam logic [4:0] ADR_MODE = 5'h0C;
  localparam logic [4:0] ADR_PRESCALE = 5'h10;
  localparam logic [4:0] ADR_SECONDARY = 5'h14;
  localparam logic [4:0] ADR_PRIMARY = 5'h18;
  localparam logic [4:0] ADR_PININT = 5'h1C;
  // Control register fields
  localparam int CTRL_START = 0;
  localparam int CTRL_STATUS = 1;
  localparam int CTRL_FSTOP = 2;
  // One-shot control fields
  localparam int OS_START = 0;
  localparam int OS_STOP = 1;
  localparam int OS_ACTIVE = 2;
  // I/O control fields
  localparam int IO_POL = 0;
  localparam int IO_EDGE = 2;
  localparam int IO_PIN_EN = 3;
  // Pin interrupt control fields
  localparam int PI_BOTH = 0;
  localparam int PI_SENSE = 1;
  localparam int PI_REQ = 3;
  // Count source selection in the mode register, bits 1:0
  localparam logic [1:0] SRC_DIV1 = 2'h0;
  localparam logic [1:0] SRC_DIV8 = 2'h1;
  localparam logic [1:0] SRC_COMP = 2'h2;
  localparam logic [1:0] SRC_DIV2 = 2'h3;
  localparam logic [7:0] RST_COUNT = 8'hFF;
  localparam logic [7:0] RST_ZERO = 8'h00;
endpackage : tos_pkg

// ---- verif/tos_checker.sv ----
`timescale 1ns/100ps
module tos_checker (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic timer_pulse_out,
  input wire logic timer_irq
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  // Request still waiting for its answer
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // Pulse end: interrupt and output flip share one edge
  sequence s_end;
    timer_irq && $changed(timer_pulse_out);
  endsequence
  chk_ack_next: assert property (s_req |=> wb_ack_o)
    else $error("no ack after request");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i) && wb_cyc_i)
    else $error("ack without request");
  chk_irq_end: assert property (timer_irq |-> s_end)
    else $error("irq apart from pulse end");
  chk_irq_gap: assert property (timer_irq |=> !timer_irq [*2])
    else $error("irq too long or too close");
  chk_pulse_hold: assert property ($changed(timer_pulse_out) && !timer_irq |=>
    $stable(timer_pulse_out)) else $error("pulse shorter than two clocks");
  chk_pulse_tail: assert property (timer_irq |->
    $past(timer_pulse_out, 1) == $past(timer_pulse_out, 2)) else $error("pulse tail short");
  chk_idle_after: assert property (s_end |=> $stable(timer_pulse_out) && !timer_irq)
    else $error("output left idle level");
endmodule : tos_checker
bind tos_timer tos_checker u_chk (.*);

// ---- verif/tos_pin_model.sv ----
`timescale 1ns/100ps
// Pulled-up trigger pin, driven low for six clocks per kick
module tos_pin_model (
  input wire logic mclk,
  input wire logic kick,
  output logic pin
);
  logic [2:0] low_q = 3'h0;
  // Low long enough for the pin synchroniser to see both edges
  always @(posedge mclk) begin
    if (kick) low_q <= 3'h6;
    else if (low_q != 3'h0) low_q <= low_q - 3'h1;
  end
  assign pin = (low_q == 3'h0);
endmodule : tos_pin_model

// ---- verif/tb.sv ----
`timescale 1ns/100ps
module tb;
  logic mclk, sys_rst, wb_we_i, wb_cyc_i, wb_stb_i, comp_underflow, kick, prev_out;
  logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o;
  logic [3:0] wb_sel_i;
  logic [1:0] cdiv;
  logic [7:0] rv;
  logic wb_ack_o, ext_trigger_pin, timer_pulse_out, timer_irq;
  int fail_count = 0, cmp_count = 0, ncyc = 0, t_chg = 0, t_end = 0;
  // Prescale, primary, source code, polarity, pulse length in clocks
  // Length is ticks times source period plus the one-clock end delay
  int rows [5][5] = '{'{0, 1, 0, 0, 3}, '{2, 3, 3, 1, 25}, '{1, 0, 1, 0, 17},
    '{0, 4, 2, 1, 16}, '{0, 255, 0, 0, 257}};
  logic [4:0] sa [3] = '{tos_pkg::ADR_ONESHOT, tos_pkg::ADR_CTRL, tos_pkg::ADR_CTRL};
  logic [7:0] sd [3] = '{8'h02, 8'h04, 8'h00};
  tos_timer DUT (.*);
  tos_pin_model u_pin (.mclk(mclk), .kick(kick), .pin(ext_trigger_pin));
  // 20 MHz clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // Companion underflow every third clock
  always @(posedge mclk) begin
    cdiv <= (cdiv == 2'h2) ? 2'h0 : cdiv + 2'h1;
    comp_underflow <= (cdiv == 2'h2);
  end
  // Settled timestamps of output changes and of the interrupt
  always @(negedge mclk) begin
    ncyc++;
    if (timer_irq === 1'b1) t_end = ncyc;
    else if (timer_pulse_out !== prev_out) t_chg = ncyc;
    prev_out = timer_pulse_out;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // One classic cycle, held until ack, then a released cycle
  task automatic wb(input logic [4:0] a, input int d, input logic we = 1'b1);
    int n;
    n = 0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <=
      {2'b11, we, 27'h000_0000, a, 24'h00_0000, d[7:0]};
    do @(posedge mclk); while (wb_ack_o !== 1'b1 && n++ < 40);
    if (n >= 40) fail_count++;
    rv = wb_dat_o[7:0];
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    @(posedge mclk);
  endtask : wb
  task automatic rd(input logic [4:0] a, input int exp, input logic [7:0] m);
    wb(a, 0, 1'b0);
    chk({24'h00_0000, rv & m}, exp);
  endtask : rd
  task automatic fire();
    t_end = 0;
    wb(tos_pkg::ADR_ONESHOT, 1);
  endtask : fire
  task automatic wait_irq();
    int n;
    n = 0;
    while (t_end == 0 && n++ < 3000) @(posedge mclk);
  endtask : wait_irq
  task automatic pin_kick();
    kick <= 1'b1;
    @(posedge mclk);
    kick <= 1'b0;
  endtask : pin_kick
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  // Hang guard, far beyond the fewer than a thousand clocks the run needs
  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    tally_and_finish();
  end
  initial begin
    {sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, kick, cdiv} = 7'h40;
    comp_underflow = 1'b0;
    {wb_adr_i, wb_dat_i, wb_sel_i} = {64'h0000_0000_0000_0000, 4'hF};
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    chk({29'h0, timer_pulse_out, timer_irq, wb_ack_o}, 0);
    rd(tos_pkg::ADR_PRESCALE, tos_pkg::RST_COUNT, 8'hFF);
    rd(tos_pkg::ADR_PRIMARY, tos_pkg::RST_COUNT, 8'hFF);
    wb(5'h02, 8'hFF);
    rd(5'h02, 0, 8'hFF);
    wb(tos_pkg::ADR_SECONDARY, 5);
    $display("reset test done");
    foreach (rows[i]) begin
      wb(tos_pkg::ADR_CTRL, 0);
      wb(tos_pkg::ADR_IOCTRL, rows[i][3]);
      wb(tos_pkg::ADR_MODE, rows[i][2]);
      wb(tos_pkg::ADR_PRESCALE, rows[i][0]);
      wb(tos_pkg::ADR_PRIMARY, rows[i][1]);
      rd(tos_pkg::ADR_PRESCALE, rows[i][0], 8'hFF);
      rd(tos_pkg::ADR_PRIMARY, rows[i][1], 8'hFF);
      chk(32'(timer_pulse_out), rows[i][3]);
      wb(tos_pkg::ADR_CTRL, 1);
      rd(tos_pkg::ADR_CTRL, 3, 8'hFF);
      fire();
      wait_irq();
      chk(t_end - t_chg, rows[i][4]);
      rd(tos_pkg::ADR_PRIMARY, rows[i][1], 8'hFF);
      rd(tos_pkg::ADR_ONESHOT, 0, 8'h04);
      $display("row %0d done", i);
    end
    wb(tos_pkg::ADR_CTRL, 0);
    wb(tos_pkg::ADR_PRESCALE, 3);
    wb(tos_pkg::ADR_PRIMARY, 9);
    foreach (sa[i]) begin
      wb(tos_pkg::ADR_CTRL, 1);
      fire();
      repeat (8) @(posedge mclk);
      chk(32'(timer_pulse_out), 1);
      wb(sa[i], sd[i]);
      chk(32'(timer_pulse_out), 0);
      rd(tos_pkg::ADR_PRIMARY, 9, 8'hFF);
      rd(tos_pkg::ADR_ONESHOT, 0, 8'h04);
    end
    fire();
    pin_kick();
    repeat (20) @(posedge mclk);
    chk(32'(timer_pulse_out), 0);
    wb(tos_pkg::ADR_CTRL, 1);
    pin_kick();
    repeat (20) @(posedge mclk);
    chk(32'(timer_pulse_out), 0);
    rd(tos_pkg::ADR_ONESHOT, 0, 8'h04);
    $display("stop and refusal tests done");
    wb(tos_pkg::ADR_PININT, 0);
    wb(tos_pkg::ADR_IOCTRL, 8'h08);
    t_end = 0;
    pin_kick();
    repeat (10) @(posedge mclk);
    wb(tos_pkg::ADR_PININT, 0);
    pin_kick();
    wb(tos_pkg::ADR_ONESHOT, 1);
    rd(tos_pkg::ADR_PININT, 8'h08, 8'h08);
    rd(tos_pkg::ADR_ONESHOT, 8'h04, 8'h04);
    wait_irq();
    chk(t_end - t_chg, 41);
    fire();
    wb(tos_pkg::ADR_PRIMARY, 4);
    wait_irq();
    chk(t_end - t_chg, 41);
    fire();
    wait_irq();
    chk(t_end - t_chg, 21);
    $display("pin and rewrite tests done");
    tally_and_finish();
  end
endmodule : tb
